//--- phy_mgmt_regs.sv
// AXI4-Lite register bank for PHY event flags, special status and indirect MMD map
// Contract
// - bit 2 latches on parallel detect fault
// - bit 1 latches on page received
// - reading flag register clears all flags
// - flags latch only when enabled; hold until read
// - enable bits 9:1, reset zero, rest reserved
// - enable bit 9 gates link-up event
// - enable bit 8 gates wake-on-LAN event
// - enable bit 7 gates energy-detected rising
// - enable bit 6 gates autoneg complete
// - enable bit 5 gates remote fault
// - enable bit 4 gates link-down event
// - enable bit 3 gates partner acknowledge
// - enable bit 2 gates parallel fault
// - enable bit 1 gates page received
// - status bit 12 shows autoneg done
// - bits 11:5 reset 0000010b, software rewrites it
// - bits 4:2 report speed and duplex
// - indirect registers reached only through window
// - decode only devices 3, 7, 30
// - device 3 low indices decoded
// - device 3 wake-up registers decoded
// - device 7 indices 5, 6, 60, 61
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
module phy_mgmt_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire phy_mgmt_pkg::phy_status_t phy_status,
    output logic phy_irq
);
    // Slot map behind the indirect window
    function automatic phy_mgmt_pkg::mmd_decode_t mmd_decode(input logic [4:0] dev, input logic [15:0] idx);
        phy_mgmt_pkg::mmd_decode_t d;
        d = '0;
        if (dev == phy_mgmt_pkg::DEV_PCS) begin
            d.hit = 1'b1;
            unique case (idx)
                16'h0000: d.slot = 5'h00;
                16'h0001: begin
                    d.slot = 5'h01;
                    d.ro = 1'b1;
                end
                16'h0005: begin
                    d.slot = 5'h02;
                    d.ro = 1'b1;
                end
                16'h0006: begin
                    d.slot = 5'h03;
                    d.ro = 1'b1;
                end
                16'h0014: begin
                    d.slot = 5'h04;
                    d.ro = 1'b1;
                end
                16'h0016: begin
                    d.slot = 5'h05;
                    d.ro = 1'b1;
                end
                16'h8010: d.slot = 5'h06;
                16'h8011: d.slot = 5'h07;
                16'h8012: d.slot = 5'h08;
                // Byte masks and receive address words pack into consecutive slots
                16'h8021, 16'h8022, 16'h8023, 16'h8024,
                16'h8025, 16'h8026, 16'h8027, 16'h8028: d.slot = 5'(idx - 16'h8018);
                16'h8061, 16'h8062, 16'h8063: d.slot = 5'(idx - 16'h8050);
                default: d.hit = 1'b0;
            endcase
        end else if (dev == phy_mgmt_pkg::DEV_AN) begin
            d.hit = 1'b1;
            d.ro = 1'b1;
            unique case (idx)
                16'h0005: d.slot = 5'h14;
                16'h0006: d.slot = 5'h15;
                16'h003c: begin
                    d.slot = 5'h16;
                    d.ro = 1'b0;
                end
                16'h003d: d.slot = 5'h17;
                default: d.hit = 1'b0;
            endcase
        end else if (dev == phy_mgmt_pkg::DEV_VEND) begin
            d.hit = 1'b1;
            d.ro = 1'b1;
            unique case (idx)
                16'h0002: d.slot = 5'h18;
                16'h0003: d.slot = 5'h19;
                16'h0005: d.slot = 5'h1a;
                16'h0006: d.slot = 5'h1b;
                16'h0008: d.slot = 5'h1c;
                16'h000e: d.slot = 5'h1d;
                16'h000f: d.slot = 5'h1e;
                default: d.hit = 1'b0;
            endcase
        end
        return d;
    endfunction

    // Fixed contents of read-only slots; identity slots read zero
    function automatic logic [15:0] ro_value(input logic [4:0] slot);
        logic [15:0] v;
        v = 16'h0000;
        unique case (slot)
            5'h02, 5'h14, 5'h1a: v = phy_mgmt_pkg::PRESENT1_VALUE;
            5'h03, 5'h15: v = phy_mgmt_pkg::PRESENT2_VALUE;
            5'h1b: v = phy_mgmt_pkg::VEND_PRESENT2_VALUE;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Bus state
    logic aw_full_r;
    logic aw_full_nxt;
    logic w_full_r;
    logic w_full_nxt;
    logic [4:0] aw_idx_r;
    logic [4:0] aw_idx_nxt;
    logic [15:0] wdat_r;
    logic [15:0] wdat_nxt;
    logic [1:0] wlane_r;
    logic [1:0] wlane_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Register state
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    logic [15:0] enable_r;
    logic [15:0] enable_nxt;
    logic [6:0] scs_fix_r;
    logic [6:0] scs_fix_nxt;
    logic [15:0] ind_ctl_r;
    logic [15:0] ind_ctl_nxt;
    // One address word shared by all devices; switching device keeps it
    logic [15:0] ind_addr_r;
    logic [15:0] ind_addr_nxt;
    logic [15:0] mmd_mem_r [phy_mgmt_pkg::SLOTS];
    logic [15:0] mmd_mem_nxt [phy_mgmt_pkg::SLOTS];
    logic irq_r;
    logic irq_nxt;
    phy_mgmt_pkg::phy_status_t status_q_r;
    phy_mgmt_pkg::phy_status_t status_q_nxt;

    logic do_write;
    logic do_read;
    logic [4:0] ar_idx;
    logic [15:0] merged;
    logic [15:0] events;
    logic [15:0] scs_value;
    logic [15:0] ind_read;
    logic [1:0] ind_func;
    phy_mgmt_pkg::mmd_decode_t dec;

    // Ready is the inverse of a full holding slot
    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready = !w_full_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign phy_irq = irq_r;

    assign do_write = aw_full_r && w_full_r && !bvalid_r;
    assign do_read = s_axi_arvalid && !rvalid_r;
    assign ar_idx = s_axi_araddr[6:2];
    assign ind_func = ind_ctl_r[phy_mgmt_pkg::IND_FUNC_HI:phy_mgmt_pkg::IND_FUNC_LO];
    assign dec = mmd_decode(ind_ctl_r[phy_mgmt_pkg::IND_DEV_HI:phy_mgmt_pkg::IND_DEV_LO], ind_addr_r);
    // A lane with its strobe clear writes zero, not the old byte
    assign merged = {wlane_r[1] ? wdat_r[15:8] : 8'h00, wlane_r[0] ? wdat_r[7:0] : 8'h00};

    // Edges are taken against the previous sample of the level inputs
    always_comb begin
        events = 16'h0000;
        events[9] = phy_status.link_ok && !status_q_r.link_ok;
        events[8] = phy_status.wake_on_lan_event;
        events[7] = phy_status.energy_detected && !status_q_r.energy_detected;
        events[6] = phy_status.autoneg_done && !status_q_r.autoneg_done;
        events[5] = phy_status.remote_fault;
        events[4] = !phy_status.link_ok && status_q_r.link_ok;
        events[3] = phy_status.partner_ack;
        events[2] = phy_status.parallel_detect_fault;
        events[1] = phy_status.page_received;
    end

    always_comb begin
        scs_value = 16'h0000;
        scs_value[phy_mgmt_pkg::SCS_AN_DONE_BIT] = status_q_r.autoneg_done;
        scs_value[phy_mgmt_pkg::SCS_FIX_HI:phy_mgmt_pkg::SCS_FIX_LO] = scs_fix_r;
        scs_value[phy_mgmt_pkg::SCS_SPEED_HI:phy_mgmt_pkg::SCS_SPEED_LO] = status_q_r.speed_code;
        ind_read = ind_addr_r;
        if (ind_func != phy_mgmt_pkg::IND_FUNC_ADDR) begin
            ind_read = 16'h0000;
            if (dec.hit && dec.slot == 5'h01) begin
                ind_read = 16'h0000;
            end else if (dec.hit) begin
                ind_read = dec.ro ? ro_value(dec.slot) : mmd_mem_r[dec.slot];
            end
        end
    end

    // Bus channels
    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        aw_idx_nxt = aw_idx_r;
        wdat_nxt = wdat_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            aw_idx_nxt = s_axi_awaddr[6:2];
        end
        if (s_axi_wvalid && !w_full_r) begin
            w_full_nxt = 1'b1;
            wdat_nxt = s_axi_wdata[15:0];
            wlane_nxt = s_axi_wstrb[1:0];
        end
        if (do_write) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            unique case (aw_idx_r)
                phy_mgmt_pkg::IDX_EVENT_ENABLE,
                phy_mgmt_pkg::IDX_SPECIAL_CTL,
                phy_mgmt_pkg::IDX_EVENT_LATCH,
                phy_mgmt_pkg::IDX_INDIRECT_CTL,
                phy_mgmt_pkg::IDX_INDIRECT_DATA: bresp_nxt = phy_mgmt_pkg::RESP_OKAY;
                default: bresp_nxt = phy_mgmt_pkg::RESP_DECERR;
            endcase
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        // A new address waits until the previous answer is taken
        if (do_read) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = phy_mgmt_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            unique case (ar_idx)
                phy_mgmt_pkg::IDX_EVENT_LATCH: rdata_nxt[15:0] = flags_r;
                phy_mgmt_pkg::IDX_EVENT_ENABLE: rdata_nxt[15:0] = enable_r;
                phy_mgmt_pkg::IDX_SPECIAL_CTL: rdata_nxt[15:0] = scs_value;
                phy_mgmt_pkg::IDX_INDIRECT_CTL: rdata_nxt[15:0] = ind_ctl_r;
                phy_mgmt_pkg::IDX_INDIRECT_DATA: rdata_nxt[15:0] = ind_read;
                default: rresp_nxt = phy_mgmt_pkg::RESP_DECERR;
            endcase
        end
    end

    // Register contents
    always_comb begin
        status_q_nxt = phy_status;
        enable_nxt = enable_r;
        scs_fix_nxt = scs_fix_r;
        ind_ctl_nxt = ind_ctl_r;
        ind_addr_nxt = ind_addr_r;
        mmd_mem_nxt = mmd_mem_r;
        flags_nxt = flags_r;
        // A read clears, but an event in the same cycle still lands
        if (do_read && ar_idx == phy_mgmt_pkg::IDX_EVENT_LATCH) begin
            flags_nxt = 16'h0000;
        end
        flags_nxt = flags_nxt | (events & enable_r & phy_mgmt_pkg::EVENT_USED_MASK);
        irq_nxt = |flags_nxt;
        if (do_write) begin
            unique case (aw_idx_r)
                phy_mgmt_pkg::IDX_EVENT_ENABLE: enable_nxt = merged & phy_mgmt_pkg::EVENT_USED_MASK;
                phy_mgmt_pkg::IDX_SPECIAL_CTL: begin
                    scs_fix_nxt = merged[phy_mgmt_pkg::SCS_FIX_HI:phy_mgmt_pkg::SCS_FIX_LO];
                end
                phy_mgmt_pkg::IDX_INDIRECT_CTL: ind_ctl_nxt = merged;
                phy_mgmt_pkg::IDX_INDIRECT_DATA: begin
                    if (ind_func == phy_mgmt_pkg::IND_FUNC_ADDR) begin
                        ind_addr_nxt = merged;
                    end else if (dec.hit && !dec.ro) begin
                        mmd_mem_nxt[dec.slot] = merged;
                    end
                end
                default: begin
                    // Flag register writes are accepted and dropped
                end
            endcase
        end
    end

    // Synchronous reset clears the storage slots as well
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_idx_r <= 5'h00;
            wdat_r <= 16'h0000;
            wlane_r <= 2'h0;
            bvalid_r <= 1'b0;
            bresp_r <= phy_mgmt_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= phy_mgmt_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            flags_r <= 16'h0000;
            enable_r <= phy_mgmt_pkg::EVENT_ENABLE_RESET;
            scs_fix_r <= phy_mgmt_pkg::SCS_FIX_RESET;
            ind_ctl_r <= 16'h0000;
            ind_addr_r <= 16'h0000;
            irq_r <= 1'b0;
            status_q_r <= '0;
            for (int i = 0; i < phy_mgmt_pkg::SLOTS; i++) begin
                mmd_mem_r[i] <= 16'h0000;
            end
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            aw_idx_r <= aw_idx_nxt;
            wdat_r <= wdat_nxt;
            wlane_r <= wlane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            flags_r <= flags_nxt;
            enable_r <= enable_nxt;
            scs_fix_r <= scs_fix_nxt;
            ind_ctl_r <= ind_ctl_nxt;
            ind_addr_r <= ind_addr_nxt;
            irq_r <= irq_nxt;
            status_q_r <= status_q_nxt;
            mmd_mem_r <= mmd_mem_nxt;
        end
    end
endmodule

//--- phy_mgmt_pkg.sv
// Shared constants and types for the PHY management register bank
package phy_mgmt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [4:0] IDX_INDIRECT_CTL = 5'h0d;
    localparam logic [4:0] IDX_INDIRECT_DATA = 5'h0e;
    localparam logic [4:0] IDX_EVENT_LATCH = 5'h1d;
    localparam logic [4:0] IDX_EVENT_ENABLE = 5'h1e;
    localparam logic [4:0] IDX_SPECIAL_CTL = 5'h1f;

    // Event enable / latch layout
    localparam int EV_LO = 1;
    localparam int EV_HI = 9;
    localparam logic [15:0] EVENT_USED_MASK = 16'h03fe;
    localparam logic [15:0] EVENT_ENABLE_RESET = 16'h0000;

    // Special control/status layout
    localparam int SCS_AN_DONE_BIT = 12;
    localparam int SCS_FIX_HI = 11;
    localparam int SCS_FIX_LO = 5;
    localparam int SCS_SPEED_HI = 4;
    localparam int SCS_SPEED_LO = 2;
    localparam logic [6:0] SCS_FIX_RESET = 7'h02;

    // Indirect access control layout
    localparam int IND_FUNC_HI = 15;
    localparam int IND_FUNC_LO = 14;
    localparam int IND_DEV_HI = 4;
    localparam int IND_DEV_LO = 0;
    localparam logic [1:0] IND_FUNC_ADDR = 2'h0;
    localparam logic [1:0] IND_FUNC_DATA = 2'h1;

    // Indirect device addresses
    localparam logic [4:0] DEV_PCS = 5'h03;
    localparam logic [4:0] DEV_AN = 5'h07;
    localparam logic [4:0] DEV_VEND = 5'h1e;

    // Read-only devices-present words
    localparam logic [15:0] PRESENT1_VALUE = 16'h0088;
    localparam logic [15:0] PRESENT2_VALUE = 16'h0000;
    localparam logic [15:0] VEND_PRESENT2_VALUE = 16'h4000;

    // Number of storage slots behind the indirect window
    localparam int SLOTS = 31;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Event sources from the PHY core; pulses except the levels noted
    typedef struct packed {
        logic link_ok; // Level
        logic wake_on_lan_event;
        logic energy_detected; // Level
        logic autoneg_done; // Level
        logic remote_fault;
        logic partner_ack;
        logic parallel_detect_fault;
        logic page_received;
        logic [2:0] speed_code; // Level
    } phy_status_t;

    typedef struct packed {
        logic hit;
        logic ro;
        logic [4:0] slot;
    } mmd_decode_t;
endpackage

//--- phy_mgmt_regs_checker.sv
// Port checker for the PHY management register bank
`timescale 1ns/1ns
module phy_mgmt_regs_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire phy_mgmt_pkg::phy_status_t phy_status,
    input wire logic phy_irq
);
    phy_mgmt_pkg::phy_status_t prev_r;
    phy_mgmt_pkg::phy_status_t prev_nxt;
    logic ev;
    logic ar_take;
    logic latch_rd;
    always_comb begin
        prev_nxt = rst_b ? phy_status : '0;
    end
    always_ff @(posedge clk) begin
        prev_r <= prev_nxt;
    end
    // Any source event, enabled or not; levels count on their edges
    assign ev = |{phy_status[9], phy_status[6:3], phy_status[10] ^ prev_r[10], phy_status[8:7] & ~prev_r[8:7]};
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign latch_rd = ar_take && s_axi_araddr[6:2] == phy_mgmt_pkg::IDX_EVENT_LATCH;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_read_latency: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:16] == 16'h0000)
        else $error("read answer malformed");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
    a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_unmapped_read: assert property (ar_take
        && !(s_axi_araddr[6:2] inside {5'h0d, 5'h0e, 5'h1d, 5'h1e, 5'h1f})
        |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    a_reserved_bits: assert property (ar_take && s_axi_araddr[6:2] inside {5'h1d, 5'h1e}
        |=> (s_axi_rdata & ~32'h0000_03fe) == 32'h0) else $error("reserved bits set");
    a_irq_cause: assert property ($rose(phy_irq) |-> $past(ev)) else $error("irq without event");
    a_irq_fall: assert property ($fell(phy_irq) |-> $past(latch_rd)) else $error("irq fell without read");
    a_read_clears: assert property (latch_rd && !ev |=> !phy_irq) else $error("flags kept after read");
endmodule
bind phy_mgmt_regs phy_mgmt_regs_checker chk (.*);

//--- phy_mgmt_host.sv
// Software-side register access model speaking AXI4-Lite
`timescale 1ns/1ns
module phy_mgmt_host (
    input wire logic clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    localparam logic [7:0] CTL_A = {1'b0, phy_mgmt_pkg::IDX_INDIRECT_CTL, 2'h0};
    localparam logic [7:0] DATA_A = {1'b0, phy_mgmt_pkg::IDX_INDIRECT_DATA, 2'h0};
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    end
    // Released payloads are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid);
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Data register is reread after a write; no post-increment
    task automatic mmd(input logic [4:0] dev, input logic [15:0] idx, input logic w, input logic [15:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        wr(CTL_A, {phy_mgmt_pkg::IND_FUNC_ADDR, 9'h000, dev}, r);
        wr(DATA_A, idx, r);
        wr(CTL_A, {phy_mgmt_pkg::IND_FUNC_DATA, 9'h000, dev}, r);
        if (w) wr(DATA_A, d, r);
        rd(DATA_A, q, r);
    endtask
endmodule

//--- phy_mgmt_regs_bench.sv
// Self-checking bench for the PHY management register bank
`timescale 1ns/1ns
module phy_mgmt_regs_bench;
    typedef struct packed {
        logic [1:0] op;
        logic [4:0] dev;
        logic [15:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, phy_irq;
    phy_mgmt_pkg::phy_status_t phy_status = 11'h005;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    row_t r;
    logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
    // Ops: 0 read, 1 write then read, 2 indirect write then read, 3 indirect read
    row_t rows [15] = '{
        '{2'h0, 5'h00, 16'h0078, 16'h0000, 16'h0000},
        '{2'h0, 5'h00, 16'h007c, 16'h0000, 16'h0054},
        '{2'h0, 5'h00, 16'h0074, 16'h0000, 16'h0000},
        '{2'h1, 5'h00, 16'h0078, 16'hffff, 16'h03fe},
        '{2'h1, 5'h00, 16'h007c, 16'h0040, 16'h0054},
        '{2'h3, 5'h03, 16'h0005, 16'h0000, 16'h0088},
        '{2'h3, 5'h07, 16'h0005, 16'h0000, 16'h0088},
        '{2'h3, 5'h1e, 16'h0006, 16'h0000, 16'h4000},
        '{2'h3, 5'h04, 16'h0005, 16'h0000, 16'h0000},
        '{2'h2, 5'h03, 16'h0000, 16'h1234, 16'h1234},
        '{2'h2, 5'h03, 16'h8010, 16'ha5a5, 16'ha5a5},
        '{2'h2, 5'h03, 16'h8021, 16'h5a5a, 16'h5a5a},
        '{2'h2, 5'h07, 16'h003c, 16'h0f0f, 16'h0f0f},
        '{2'h2, 5'h03, 16'h8013, 16'hffff, 16'h0000},
        '{2'h3, 5'h03, 16'h8010, 16'h0000, 16'ha5a5}
    };
    always #5 clk = ~clk;
    phy_mgmt_regs uut (.*);
    phy_mgmt_host host (.*);
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Whole run needs well under two thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        int s;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            r = rows[i];
            if (r.op == 2'h1) host.wr(r.a[7:0], r.d, rs);
            if (r.op[1]) host.mmd(r.dev, r.a, r.op == 2'h2, r.d, got, rs);
            else host.rd(r.a[7:0], got, rs);
            chk("row data", got, {16'h0000, r.e});
            chk("row resp", {30'h0, rs}, 32'h0);
        end
        host.rd(8'h40, got, rs);
        chk("unmapped read", {30'h0, rs}, 32'h3);
        host.wr(8'h44, 16'hffff, rs);
        chk("unmapped write", {30'h0, rs}, 32'h3);
        // Link pulse also drops the link, so one read sees both edges
        for (int i = 1; i <= 9; i++) begin
            if (i == 4) continue;
            s = i > 4 ? i + 1 : i + 2;
            @(posedge clk);
            phy_status[s] <= 1'b1;
            @(posedge clk);
            phy_status[s] <= 1'b0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("irq raised", {31'h0, phy_irq}, 32'h1);
            host.rd(8'h74, got, rs);
            chk("flags", got, i == 9 ? 32'h0210 : 32'h1 << i);
            @(negedge clk);
            chk("irq cleared", {31'h0, phy_irq}, 32'h0);
        end
        host.wr(8'h78, 16'h0004, rs);
        @(posedge clk);
        phy_status[4:3] <= 2'h3;
        @(posedge clk);
        phy_status[4:3] <= 2'h0;
        host.rd(8'h74, got, rs);
        chk("masked flags", got, 32'h0004);
        @(posedge clk);
        phy_status.autoneg_done <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            phy_status.speed_code <= codes[i];
            repeat (2) @(posedge clk);
            host.rd(8'h7c, got, rs);
            chk("special", got, 32'h1040 | {27'h0, codes[i], 2'h0});
        end
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        host.rd(8'h78, got, rs);
        chk("enable after reset", got, 32'h0);
        stop_test();
    end
endmodule
